// ==== sim/matched_filter_polar_agc_tb.sv ====
// Purpose: Self-checking bench for the main path block
// Assumes: Zero wait APB slave, source model upstream
// Notes:   Counts follow from rates, values from formats
`timescale 1ns/1ns
`default_nettype none
module matched_filter_polar_agc_tb;
    import mfpa_pkg::*;
    logic        clk_i = 0;
    logic        sys_rst_i = 1;
    logic        psel_i = 0;
    logic        penable_i = 0;
    logic        pwrite_i = 0;
    logic [7:0]  paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic [31:0] prdata_o, rd, d, x;
    logic        pready_o, pslverr_o, er, sv, ev, mv, pv, pe, pd;
    logic [9:0]  si, sq, ei, eq, mi, mq, last_i;
    logic [9:0]  fi = '0;
    logic [9:0]  fq = '0;
    logic [7:0]  mag, ph, gain, g1;
    logic [7:0]  num = '0;
    logic        go = 0;
    logic        rnd = 0;
    logic [31:0] msk [3] = '{32'hf3e, 32'hff, 32'hffff_ffff};
    logic [9:0]  ti [3] = '{10'h100, 10'h000, 10'h300};
    logic [9:0]  tq [3] = '{10'h000, 10'h100, 10'h000};
    logic [7:0]  tp [3] = '{8'h00, 8'h40, 8'h80};
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n_in, n_mid, n_end, n_pv, n_pe;

    mfpa_core dut_u (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .samp_i_i(si), .samp_q_i(sq), .samp_vld_i(sv), .end_i_o(ei),
        .end_q_o(eq), .end_vld_o(ev), .mid_i_o(mi), .mid_q_o(mq),
        .mid_vld_o(mv), .mag_o(mag), .phase_o(ph), .phase_vld_o(pv),
        .phase_err_vld_o(pe), .agc_gain_o(gain),
        .power_detect_flag_o(pd));
    mfpa_src src_u (.clk_i, .go_i(go), .num_i(num), .rnd_i(rnd),
        .fix_i_i(fi), .fix_q_i(fq), .samp_i_o(si), .samp_q_o(sq),
        .samp_vld_o(sv));

    // Clock, 40 ns period
    initial forever #20 clk_i = ~clk_i;

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // Count stream events, keep last output, cut hangs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
        n_in  <= n_in + int'(sv);
        n_mid <= n_mid + int'(mv);
        n_end <= n_end + int'(ev);
        n_pv  <= n_pv + int'(pv);
        n_pe  <= n_pe + int'(pe);
        if (ev) last_i <= ei;
        else if (mv) last_i <= mi;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Exp when within tol of it, else the value seen
    function automatic logic [7:0] near(logic [7:0] g, e, t);
        return (8'(g - e + t) <= 8'(2 * t)) ? e : g;
    endfunction : near

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= v;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic run(input logic [7:0] n, input logic r,
                       input logic [9:0] a, input logic [9:0] b);
        @(negedge clk_i);
        {n_in, n_mid, n_end, n_pv, n_pe} = '0;
        @(posedge clk_i);
        go  <= 1'b1;
        num <= n;
        rnd <= r;
        fi  <= a;
        fq  <= b;
        @(posedge clk_i);
        go  <= 1'b0;
        while (n_in < int'(n)) @(posedge clk_i);
        repeat (40) @(posedge clk_i);
    endtask : run

    // Main sequence
    initial begin
        void'($urandom(32'h24565dce));
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), '0);
            chk(rd, REG_RST);
            d = $urandom;
            x = d & msk[i];
            if (i == 0 && x[5:3] > DEC_MAX) x[5:3] = DEC_MAX;
            apb(1'b1, 8'(4 * i), d);
            apb(1'b0, 8'(4 * i), '0);
            chk(rd, x);
        end
        apb(1'b1, ADDR_CFG, 32'h38);
        apb(1'b0, ADDR_CFG, '0);
        chk(rd, 32'h28);
        apb(1'b1, ADDR_STAT, '1);
        apb(1'b0, 8'h10, '0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, ADDR_CFG, '0);
        apb(1'b1, ADDR_AGC, 32'h8000_4040);
        run(2, 1'b0, 10'h020, 10'h000);
        chk(gain, 8'h40);
        run(2, 1'b0, 10'h020, 10'h010);
        chk(last_i, 10'h040);
        chk(eq, 10'h020);
        chk(mq, 10'h020);
        apb(1'b1, ADDR_AGC, 32'h8000_0000);
        // Gain of two lingers until an end sample meets the new limits
        run(2, 1'b0, '0, '0);
        chk(gain, 8'h00);
        apb(1'b1, ADDR_PWR, 32'h30);
        for (int i = 0; i < 3; i++) begin
            run(1, 1'b0, ti[i], tq[i]);
            chk(near(ph, tp[i], 1), tp[i]);
            chk(near(mag, 8'h34, 2), 8'h34);
            chk(pd, 1'b1);
        end
        apb(1'b1, ADDR_PWR, 32'h40);
        run(1, 1'b0, 10'h100, 10'h000);
        chk(pd, 1'b0);
        // Steady input 64 through taps summing to 290, shifted by 8
        apb(1'b1, ADDR_CFG, 32'h2);
        run(16, 1'b0, 10'h040, 10'h000);
        chk(last_i, 10'h048);
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, ADDR_CFG, 32'(((c % 2) << 1) | 4 | (c << 3)));
            run(64, 1'b1, '0, '0);
            chk(n_mid + n_end, 64 >> c);
            chk(n_mid, n_end);
            chk(n_pe, n_end);
            chk(n_pv, n_mid + n_end);
        end
        apb(1'b1, ADDR_CFG, 32'h11c);
        run(64, 1'b1, '0, '0);
        chk(n_mid + n_end, 8);
        chk(n_pv + n_pe, 128);
        apb(1'b1, ADDR_CFG, '0);
        apb(1'b1, ADDR_AGC, 32'h0f00_ff00);
        run(32, 1'b1, '0, '0);
        g1 = gain;
        chk(g1 != 8'h00, 1'b1);
        apb(1'b1, ADDR_AGC, 32'h8f00_ff00);
        run(32, 1'b1, '0, '0);
        chk(gain, g1);
        apb(1'b1, ADDR_AGC, 32'h0fff_ff00);
        run(32, 1'b1, '0, '0);
        chk(gain < g1, 1'b1);
        end_sim();
    end
endmodule : matched_filter_polar_agc_tb
`default_nettype wire

// ==== sim/mfpa_src.sv ====
// Purpose: Upstream sample source feeding the main path
// Assumes: Counted bursts with random spacing
// Notes:   Data lines invert between samples, never stale
`timescale 1ns/1ns
`default_nettype none
module mfpa_src (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] num_i,
    input  wire logic       rnd_i,
    input  wire logic [9:0] fix_i_i,
    input  wire logic [9:0] fix_q_i,
    output logic      [9:0] samp_i_o,
    output logic      [9:0] samp_q_o,
    output logic            samp_vld_o
);
    int left = 0;
    initial samp_i_o = '0;
    initial samp_q_o = '0;
    initial samp_vld_o = 1'b0;
    // Emit a counted burst, gaps at random
    always @(posedge clk_i) begin
        if (go_i) left <= num_i;
        if (left > 0 && $urandom_range(1, 0) == 1) begin
            left       <= left - 1;
            samp_vld_o <= 1'b1;
            samp_i_o   <= rnd_i ? 10'($urandom) : fix_i_i;
            samp_q_o   <= rnd_i ? 10'($urandom) : fix_q_i;
        end else begin
            samp_vld_o <= 1'b0;
            samp_i_o   <= ~samp_i_o;
            samp_q_o   <= ~samp_q_o;
        end
    end
endmodule : mfpa_src
`default_nettype wire

// ==== verilog/mfpa_core.sv ====
// Purpose: Matched filters, decimator, polar converter and AGC main path
// Assumes: Samples arrive on clk_i with a one-cycle valid strobe
// Notes:   All state lives in one struct registered by one process
//
// Decided for this implementation: the address map and the APB register port.

`timescale 1ns/1ns
`default_nettype none

module mfpa_core
    import mfpa_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [9:0]  samp_i_i,
    input  wire logic [9:0]  samp_q_i,
    input  wire logic        samp_vld_i,
    output logic      [9:0]  end_i_o,
    output logic      [9:0]  end_q_o,
    output logic             end_vld_o,
    output logic      [9:0]  mid_i_o,
    output logic      [9:0]  mid_q_o,
    output logic             mid_vld_o,
    output logic      [7:0]  mag_o,
    output logic      [7:0]  phase_o,
    output logic             phase_vld_o,
    output logic             phase_err_vld_o,
    output logic      [7:0]  agc_gain_o,
    output logic             power_detect_flag_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic               fir_en;
        logic               id_en;
        logic [2:0]         dec;
        logic [2:0]         shf;
        logic               pol_src;
        logic [7:0]         pwr_thr;
        logic               agc_dis;
        logic [2:0]         agc_e;
        logic [3:0]         agc_m;
        logic [7:0]         agc_thr;
        logic [7:0]         agc_up;
        logic [7:0]         agc_lo;
        logic signed [9:0]  g_i;
        logic signed [9:0]  g_q;
        logic               g_v;
        logic [14:0][9:0]   sr_i;
        logic [14:0][9:0]   sr_q;
        logic               fpend;
        logic signed [9:0]  f_i;
        logic signed [9:0]  f_q;
        logic               f_v;
        logic signed [14:0] acc_i;
        logic signed [14:0] acc_q;
        logic [3:0]         cnt;
        logic signed [9:0]  dmp_i;
        logic signed [9:0]  dmp_q;
        logic               dmp_ph;
        logic signed [9:0]  s_i;
        logic signed [9:0]  s_q;
        logic               s_v;
        logic               sym_ph;
        logic [9:0]         end_i;
        logic [9:0]         end_q;
        logic               end_v;
        logic [9:0]         mid_i;
        logic [9:0]         mid_q;
        logic               mid_v;
        logic [7:0]         mag;
        logic [7:0]         ph;
        logic               pv;
        logic               pend;
        logic               pdet;
        logic [19:0]        agc_acc;
    } mfpa_state_s;

    mfpa_state_s r_ff;
    mfpa_state_s nxt_r;

    // ----------------------------------------------------------------
    // Arithmetic helpers
    // ----------------------------------------------------------------
    function automatic logic signed [9:0] sat10(input logic signed [23:0] v);
        logic signed [9:0] res;
        res = v[9:0];
        if (v > 24'sd511) begin
            res = 10'sd511;
        end else if (v < -24'sd512) begin
            res = -10'sd512;
        end
        return res;
    endfunction : sat10

    // Gain multiplier (1 + m/64) * 2^e
    function automatic logic signed [9:0] gain_apply(
        input logic signed [9:0] x,
        input logic [7:0]        g
    );
        logic signed [23:0] p;
        p = 24'(x) * $signed({17'h0, 7'(7'd64 + {1'b0, g[5:0]})});
        p = p <<< g[7:6];
        return sat10(p >>> 6);
    endfunction : gain_apply

    // CORDIC vectoring: {magnitude, phase}
    function automatic logic [15:0] polar(
        input logic signed [9:0] xi,
        input logic signed [9:0] yi
    );
        logic signed [13:0] x;
        logic signed [13:0] y;
        logic signed [13:0] xt;
        logic [15:0]        z;
        logic [23:0]        m;
        x = 14'(xi);
        y = 14'(yi);
        z = 16'h0000;
        if (x < 0) begin
            x = -x;
            y = -y;
            z = HALF_TURN;
        end
        for (int k = 0; k < 8; k++) begin
            xt = x;
            if (y >= 0) begin
                x = x + (y >>> k);
                y = y - (xt >>> k);
                z = z + ATAN_TAB[k];
            end else begin
                x = x - (y >>> k);
                y = y + (xt >>> k);
                z = z - ATAN_TAB[k];
            end
        end
        m = ({10'h000, x} * MAG_SCALE) >> MAG_SHIFT;
        if (m > 24'h0000ff) begin
            m = 24'h0000ff;
        end
        return {m[7:0], z[15:8]};
    endfunction : polar

    // ----------------------------------------------------------------
    // FIR tap products
    // ----------------------------------------------------------------
    logic signed [23:0] tap_i [FIR_TAPS];
    logic signed [23:0] tap_q [FIR_TAPS];

    genvar t;
    generate
        for (t = 0; t < FIR_TAPS; t++) begin : g_tap
            assign tap_i[t] = 24'($signed(r_ff.sr_i[t])) * 24'(FIR_COEF[t]);
            assign tap_q[t] = 24'($signed(r_ff.sr_q[t])) * 24'(FIR_COEF[t]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic               wr;
    logic               id_on;
    logic [4:0]         id_len;
    logic signed [23:0] fs_i;
    logic signed [23:0] fs_q;
    logic signed [14:0] a_i;
    logic signed [14:0] a_q;
    logic signed [9:0]  d_i;
    logic signed [9:0]  d_q;
    logic               src_v;
    logic signed [9:0]  src_i;
    logic signed [9:0]  src_q;
    logic [15:0]        pol;
    logic signed [8:0]  err;
    logic signed [21:0] inc;
    logic signed [21:0] acc_n;
    logic signed [21:0] lim_hi;
    logic signed [21:0] lim_lo;

    always_comb begin
        nxt_r  = r_ff;
        wr     = psel_i && penable_i && pwrite_i;
        id_on  = r_ff.id_en && (r_ff.dec != 3'h0);
        id_len = 5'h01 << (r_ff.dec - 3'h1);
        fs_i   = 24'sd0;
        fs_q   = 24'sd0;
        a_i    = r_ff.acc_i;
        a_q    = r_ff.acc_q;
        d_i    = r_ff.dmp_i;
        d_q    = r_ff.dmp_q;
        err    = 9'sd0;
        inc    = 22'sd0;
        acc_n  = 22'sd0;
        lim_hi = $signed({2'b00, r_ff.agc_up, AGC_FRAC0});
        lim_lo = $signed({2'b00, r_ff.agc_lo, AGC_FRAC0});

        // Register writes
        if (wr) begin
            case (paddr_i)
                ADDR_CFG: begin
                    nxt_r.fir_en  = pwdata_i[CFG_FIR_BIT];
                    nxt_r.id_en   = pwdata_i[CFG_ID_BIT];
                    nxt_r.dec     = (pwdata_i[CFG_DEC_LSB +: 3] > DEC_MAX)
                                    ? DEC_MAX : pwdata_i[CFG_DEC_LSB +: 3];
                    nxt_r.pol_src = pwdata_i[CFG_POL_BIT];
                    nxt_r.shf     = pwdata_i[CFG_SHF_LSB +: 3];
                end
                ADDR_PWR: nxt_r.pwr_thr = pwdata_i[PWR_THR_LSB +: 8];
                ADDR_AGC: begin
                    nxt_r.agc_lo  = pwdata_i[AGC_LO_LSB +: 8];
                    nxt_r.agc_up  = pwdata_i[AGC_UP_LSB +: 8];
                    nxt_r.agc_thr = pwdata_i[AGC_THR_LSB +: 8];
                    nxt_r.agc_m   = pwdata_i[AGC_M_LSB +: 4];
                    nxt_r.agc_e   = pwdata_i[AGC_E_LSB +: 3];
                    nxt_r.agc_dis = pwdata_i[AGC_DIS_BIT];
                end
                default: ;
            endcase
        end

        // Gain adjust on the incoming samples
        nxt_r.g_v = samp_vld_i;
        if (samp_vld_i) begin
            nxt_r.g_i = gain_apply($signed(samp_i_i), r_ff.agc_acc[19:12]);
            nxt_r.g_q = gain_apply($signed(samp_q_i), r_ff.agc_acc[19:12]);
        end

        // Shaped pulse FIR, one cycle behind the delay line
        for (int k = 0; k < FIR_TAPS; k++) begin
            fs_i = fs_i + tap_i[k];
            fs_q = fs_q + tap_q[k];
        end
        nxt_r.fpend = r_ff.g_v;
        if (r_ff.g_v) begin
            nxt_r.sr_i = {r_ff.sr_i[13:0], r_ff.g_i};
            nxt_r.sr_q = {r_ff.sr_q[13:0], r_ff.g_q};
        end
        if (r_ff.fir_en) begin
            nxt_r.f_v = r_ff.fpend;
            if (r_ff.fpend) begin
                nxt_r.f_i = sat10(fs_i >>> FIR_SHIFT);
                nxt_r.f_q = sat10(fs_q >>> FIR_SHIFT);
            end
        end else begin
            nxt_r.f_v = r_ff.g_v;
            if (r_ff.g_v) begin
                nxt_r.f_i = r_ff.g_i;
                nxt_r.f_q = r_ff.g_q;
            end
        end

        // Integrate and dump with two-sample summer
        nxt_r.s_v = 1'b0;
        if (r_ff.f_v) begin
            if (!id_on) begin
                nxt_r.s_i = r_ff.f_i;
                nxt_r.s_q = r_ff.f_q;
                nxt_r.s_v = 1'b1;
            end else begin
                a_i = ((r_ff.cnt == 4'h0) ? 15'sd0 : r_ff.acc_i)
                      + 15'(r_ff.f_i);
                a_q = ((r_ff.cnt == 4'h0) ? 15'sd0 : r_ff.acc_q)
                      + 15'(r_ff.f_q);
                nxt_r.acc_i = a_i;
                nxt_r.acc_q = a_q;
                if (r_ff.cnt == 4'(id_len - 5'h01)) begin
                    nxt_r.cnt    = 4'h0;
                    d_i          = sat10(24'(a_i) >>> r_ff.shf);
                    d_q          = sat10(24'(a_q) >>> r_ff.shf);
                    nxt_r.dmp_i  = d_i;
                    nxt_r.dmp_q  = d_q;
                    nxt_r.dmp_ph = ~r_ff.dmp_ph;
                    if (r_ff.dmp_ph) begin
                        nxt_r.s_i = sat10(24'(d_i) + 24'(r_ff.dmp_i));
                        nxt_r.s_q = sat10(24'(d_q) + 24'(r_ff.dmp_q));
                        nxt_r.s_v = 1'b1;
                    end
                end else begin
                    nxt_r.cnt = r_ff.cnt + 4'h1;
                end
            end
        end

        // Split into end and mid symbol streams
        nxt_r.end_v = 1'b0;
        nxt_r.mid_v = 1'b0;
        if (r_ff.s_v) begin
            nxt_r.sym_ph = ~r_ff.sym_ph;
            if (r_ff.sym_ph) begin
                nxt_r.end_i = r_ff.s_i;
                nxt_r.end_q = r_ff.s_q;
                nxt_r.end_v = 1'b1;
            end else begin
                nxt_r.mid_i = r_ff.s_i;
                nxt_r.mid_q = r_ff.s_q;
                nxt_r.mid_v = 1'b1;
            end
        end

        // Polar converter and power detector
        src_v = r_ff.pol_src ? r_ff.f_v : r_ff.s_v;
        src_i = r_ff.pol_src ? r_ff.f_i : r_ff.s_i;
        src_q = r_ff.pol_src ? r_ff.f_q : r_ff.s_q;
        pol   = polar(src_i, src_q);
        nxt_r.pv = src_v;
        if (src_v) begin
            nxt_r.mag  = pol[15:8];
            nxt_r.ph   = pol[7:0];
            nxt_r.pend = r_ff.pol_src | r_ff.sym_ph;
            nxt_r.pdet = pol[15:8] > r_ff.pwr_thr;
        end

        // AGC error detector and loop filter
        if (r_ff.pv && r_ff.pend) begin
            err = r_ff.agc_dis ? 9'sd0
                  : $signed({1'b0, r_ff.mag}) - $signed({1'b0, r_ff.agc_thr});
            inc = (22'(err) * $signed({18'h0, r_ff.agc_m})) >>> r_ff.agc_e;
            acc_n = $signed({2'b00, r_ff.agc_acc}) + inc;
            if (acc_n > lim_hi) begin
                acc_n = lim_hi;
            end
            if (acc_n < lim_lo) begin
                acc_n = lim_lo;
            end
            nxt_r.agc_acc = acc_n[19:0];
        end
    end

    // ----------------------------------------------------------------
    // Register the state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // APB read side and outputs
    // ----------------------------------------------------------------
    logic unmapped;

    assign unmapped  = (paddr_i != ADDR_CFG) && (paddr_i != ADDR_PWR)
                       && (paddr_i != ADDR_AGC) && (paddr_i != ADDR_STAT);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && unmapped;

    // Read data mux
    always_comb begin
        prdata_o = REG_RST;
        case (paddr_i)
            ADDR_CFG: begin
                prdata_o[CFG_FIR_BIT]       = r_ff.fir_en;
                prdata_o[CFG_ID_BIT]        = r_ff.id_en;
                prdata_o[CFG_DEC_LSB +: 3]  = r_ff.dec;
                prdata_o[CFG_POL_BIT]       = r_ff.pol_src;
                prdata_o[CFG_SHF_LSB +: 3]  = r_ff.shf;
            end
            ADDR_PWR:  prdata_o[PWR_THR_LSB +: 8] = r_ff.pwr_thr;
            ADDR_AGC:  prdata_o = {r_ff.agc_dis, r_ff.agc_e, r_ff.agc_m,
                                   r_ff.agc_thr, r_ff.agc_up, r_ff.agc_lo};
            ADDR_STAT: begin
                prdata_o[7:0]               = r_ff.mag;
                prdata_o[ST_PH_LSB +: 8]    = r_ff.ph;
                prdata_o[ST_GAIN_LSB +: 8]  = r_ff.agc_acc[19:12];
                prdata_o[ST_PDET_BIT]       = r_ff.pdet;
            end
            default: ;
        endcase
    end

    // Stream outputs
    assign end_i_o             = r_ff.end_i;
    assign end_q_o             = r_ff.end_q;
    assign end_vld_o           = r_ff.end_v;
    assign mid_i_o             = r_ff.mid_i;
    assign mid_q_o             = r_ff.mid_q;
    assign mid_vld_o           = r_ff.mid_v;
    assign mag_o               = r_ff.mag;
    assign phase_o             = r_ff.ph;
    assign phase_vld_o         = r_ff.pv;
    assign phase_err_vld_o     = r_ff.pv && r_ff.pend;
    assign agc_gain_o          = r_ff.agc_acc[19:12];
    assign power_detect_flag_o = r_ff.pdet;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence fir_in_s;
        r_ff.fir_en && r_ff.g_v;
    endsequence
    sequence fir_out_s;
        ##2 r_ff.f_v;
    endsequence

    fir_bypass_a: assert property ((!r_ff.fir_en && r_ff.g_v) |=>
        (r_ff.f_v && r_ff.f_i == $past(r_ff.g_i)))
        else $error("FIR bypass did not pass sample");
    fir_delay_a: assert property (fir_in_s |-> fir_out_s)
        else $error("FIR output missing two cycles after input");
    dec_bypass_a: assert property ((!id_on && r_ff.f_v) |=>
        (r_ff.s_v && r_ff.s_i == $past(r_ff.f_i)))
        else $error("Decimator bypass did not pass sample");
    id_restart_a: assert property (
        (r_ff.f_v && id_on && r_ff.cnt == 4'h0)
        |=> r_ff.acc_i == 15'($past(r_ff.f_i)))
        else $error("Accumulator carried over between intervals");
    sym_split_a: assert property (r_ff.s_v |=>
        (r_ff.end_v != r_ff.mid_v))
        else $error("Summer output not routed to one stream");
    mag_end_a: assert property ($changed(r_ff.agc_acc) |->
        ($past(r_ff.pv) && $past(r_ff.pend)))
        else $error("AGC moved without end-of-symbol magnitude");
    phase_err_a: assert property (!$past(r_ff.pol_src) |->
        (phase_err_vld_o == end_vld_o))
        else $error("Phase error strobe not on end sample");
    pwr_flag_a: assert property (r_ff.pv |->
        r_ff.pdet == (r_ff.mag > $past(r_ff.pwr_thr)))
        else $error("Power flag disagrees with magnitude");
    agc_hold_a: assert property ((r_ff.agc_dis && r_ff.pv && r_ff.pend
        && r_ff.agc_acc[19:12] >= r_ff.agc_lo
        && r_ff.agc_acc <= {r_ff.agc_up, AGC_FRAC0})
        |=> $stable(r_ff.agc_acc))
        else $error("AGC moved while loop disabled");
    agc_clamp_a: assert property ((r_ff.pv && r_ff.pend
        && r_ff.agc_lo <= r_ff.agc_up) |=>
        (r_ff.agc_acc[19:12] >= $past(r_ff.agc_lo)
        && r_ff.agc_acc <= {$past(r_ff.agc_up), AGC_FRAC0}))
        else $error("AGC accumulator outside limits");
    agc_fixed_a: assert property ((r_ff.pv && r_ff.pend
        && r_ff.agc_up == r_ff.agc_lo) |=>
        agc_gain_o == $past(r_ff.agc_up))
        else $error("Gain not fixed by equal limits");

endmodule : mfpa_core

`default_nettype wire

// ==== verilog/mfpa_pkg.sv ====
// Purpose: Constants for the matched filter, polar converter and AGC block
// Assumes: APB slave with 32-bit words, one aligned word per register
// Notes:   Every control field resets to zero

`default_nettype none

package mfpa_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG  = 8'h00;
    localparam logic [7:0] ADDR_PWR  = 8'h04;
    localparam logic [7:0] ADDR_AGC  = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_FIR_BIT  = 1;  // Shaped pulse FIR on
    localparam int CFG_ID_BIT   = 2;  // Integrate and dump on
    localparam int CFG_DEC_LSB  = 3;  // Decimation code, 3 bits
    localparam int CFG_POL_BIT  = 8;  // Polar source: 1 = I and D input
    localparam int CFG_SHF_LSB  = 9;  // Dump shifter, 3 bits
    localparam int PWR_THR_LSB  = 0;
    localparam int AGC_LO_LSB   = 0;
    localparam int AGC_UP_LSB   = 8;
    localparam int AGC_THR_LSB  = 16;
    localparam int AGC_M_LSB    = 24;
    localparam int AGC_E_LSB    = 28;
    localparam int AGC_DIS_BIT  = 31;
    localparam int ST_PH_LSB    = 8;
    localparam int ST_GAIN_LSB  = 16;
    localparam int ST_PDET_BIT  = 24;

    // ----------------------------------------------------------------
    // Reset values and arithmetic constants
    // ----------------------------------------------------------------
    localparam logic [31:0] REG_RST     = 32'h0000_0000;
    localparam logic [2:0]  DEC_MAX     = 3'h5;    // Decimation 32
    localparam int          FIR_TAPS    = 15;
    localparam int          FIR_SHIFT   = 8;
    localparam logic signed [8:0] FIR_COEF [FIR_TAPS] = '{
        9'sd2, -9'sd2, 9'sd1, 9'sd8, -9'sd16, -9'sd14, 9'sd86, 9'sd160,
        9'sd86, -9'sd14, -9'sd16, 9'sd8, 9'sd1, -9'sd2, 9'sd2};
    localparam logic [23:0] MAG_SCALE   = 24'h00007e; // 0.2 / CORDIC gain
    localparam int          MAG_SHIFT   = 10;
    localparam logic [15:0] ATAN_TAB [8] = '{
        16'h2000, 16'h12e4, 16'h09fb, 16'h0511,
        16'h028b, 16'h0146, 16'h00a3, 16'h0051};
    localparam logic [15:0] HALF_TURN   = 16'h8000;
    localparam logic [11:0] AGC_FRAC0   = 12'h000;

endpackage : mfpa_pkg

`default_nettype wire
